/* File: testbench.sv */
// Purpose: self-checking bench of the two-channel host port
// Assumes: bus pins driven at rising edges, seen four edges later
// Notes: every check is taken at a falling edge, after outputs settle
`timescale 1ns/1ps
module testbench;
  import uhp_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic stall;
  uhp_bus_in_type bus;
  logic [1:0] rx_timeout;
  logic [1:0] rx_par_err;
  logic [7:0] bus_data_out;
  logic bus_data_oe_n, chan_one_irq, chan_one_irq_oe_n, chan_two_irq, chan_two_irq_oe_n;
  logic [1:0] user_output_two_n, receive_ready_n, transmit_ready_n;
  logic [1:0] tx_valid, tx_ready, rx_valid, rx_ready;
  logic [1:0][7:0] line_format, tx_data, rx_data;
  logic [4:0] lvl [4] = '{TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3};
  int n_fail = 0;
  int n_checks = 0;
  uhp_host_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_in(bus),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
    .chan_one_irq(chan_one_irq), .chan_one_irq_oe_n(chan_one_irq_oe_n),
    .chan_two_irq(chan_two_irq), .chan_two_irq_oe_n(chan_two_irq_oe_n),
    .user_output_two_n(user_output_two_n), .receive_ready_n(receive_ready_n),
    .transmit_ready_n(transmit_ready_n), .line_format(line_format),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .rx_timeout(rx_timeout),
    .rx_parity_err(rx_par_err));
  uhp_eng_model u_eng (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .stall(stall));
  // ==========================================================
  // helpers
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic settle;
    cyc(3);
    @(negedge ref_clk);
  endtask : settle
  // one bus cycle: selects and address first, strobe, release, deselect
  task automatic acc(input logic [1:0] s, input logic rd, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    bus.select_n <= s;
    bus.addr <= a;
    bus.data <= rd ? ~bus.data : d;
    cyc(4);
    bus.read_n <= ~rd;
    bus.write_n <= rd;
    cyc(8);
    @(negedge ref_clk);
    q = bus_data_out;
    chk(8'(bus_data_oe_n), 8'(!rd || s == 2'h3));
    @(posedge ref_clk);
    bus.read_n <= 1'b1;
    bus.write_n <= 1'b1;
    cyc(5);
    bus.select_n <= 2'h3;
    settle();
  endtask : acc
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(s, 1'b0, a, d, q);
  endtask : wr
  task automatic rdc(input logic [1:0] s, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(s, 1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rdc
  // ==========================================================
  // clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    bus = BUS_IDLE;
    rst_n = 1'b0;
    stall = 1'b1;
    rx_timeout = 2'h0;
    rx_par_err = 2'h0;
    cyc(20);
    rst_n <= 1'b1;
    settle();
    chk(8'({transmit_ready_n, receive_ready_n, user_output_two_n}), 8'h0f);
    wr(2'h0, REG_SCRATCH, 8'h33);
    wr(2'h2, REG_SCRATCH, 8'h5a);
    wr(2'h3, REG_SCRATCH, 8'hff);
    rdc(2'h2, REG_SCRATCH, 8'h5a);
    rdc(2'h1, REG_SCRATCH, 8'h33);
    wr(2'h1, REG_LINE_FMT, 8'h1b);
    chk(line_format[1], 8'h1b);
    chk(line_format[0], 8'h00);
    // transmit: fill while the engine stalls, then drain
    wr(2'h2, REG_IRQ_EN, 8'h02);
    wr(2'h2, REG_LINE_OUT, 8'h08);
    chk(8'({chan_one_irq_oe_n, user_output_two_n[0], chan_one_irq}), 8'h01);
    wr(2'h2, REG_BUF_CTL, 8'h09);
    for (int i = 0; i < 19; i++)
    begin
      if (i == 17) chk(8'(transmit_ready_n[0]), 8'h00);
      wr(2'h2, REG_HOLD, 8'(i));
    end
    chk(8'({transmit_ready_n[0], chan_one_irq}), 8'h02);
    wr(2'h2, REG_BUF_CTL, 8'h01);
    chk(8'(transmit_ready_n[0]), 8'h01);
    stall = 1'b0;
    cyc(40);
    settle();
    chk(8'(u_eng.got.size()), 8'h12);
    for (int i = 0; i < 18; i++) chk(u_eng.got[i], 8'(i));
    chk(8'({transmit_ready_n[0], chan_one_irq}), 8'h01);
    rdc(2'h2, REG_BUF_CTL, 8'hc2);
    // receive: each trigger level, then block pacing
    wr(2'h1, REG_IRQ_EN, 8'h01);
    wr(2'h1, REG_LINE_OUT, 8'h08);
    for (int t = 0; t < 4; t++)
    begin
      wr(2'h1, REG_BUF_CTL, {2'(t), 6'h03});
      for (int k = 1; k < lvl[t]; k++) u_eng.send(1'b1, 8'(k));
      settle();
      chk(8'(chan_two_irq), 8'h00);
      u_eng.send(1'b1, 8'hee);
      settle();
      chk(8'({chan_two_irq, receive_ready_n[1]}), 8'h02);
    end
    wr(2'h1, REG_BUF_CTL, 8'h4b);
    for (int k = 0; k < 3; k++) u_eng.send(1'b1, 8'h10 + 8'(k));
    settle();
    chk(8'(receive_ready_n[1]), 8'h01);
    u_eng.send(1'b1, 8'h13);
    settle();
    chk(8'(receive_ready_n[1]), 8'h00);
    rdc(2'h1, REG_HOLD, 8'h10);
    chk(8'(receive_ready_n[1]), 8'h00);
    for (int k = 1; k < 4; k++) rdc(2'h1, REG_HOLD, 8'h10 + 8'(k));
    chk(8'(receive_ready_n[1]), 8'h01);
    u_eng.send(1'b1, 8'hc3);
    settle();
    chk(8'(receive_ready_n[1]), 8'h01);
    @(posedge ref_clk);
    rx_timeout <= 2'h2;
    rx_par_err <= 2'h2;
    @(posedge ref_clk);
    rx_timeout <= 2'h0;
    rx_par_err <= 2'h0;
    settle();
    chk(8'(receive_ready_n[1]), 8'h00);
    wr(2'h1, REG_BUF_CTL, 8'h01);
    rdc(2'h1, REG_HOLD, 8'hc3);
    chk(8'(receive_ready_n[1]), 8'h01);
    rdc(2'h1, REG_LINE_STATE, 8'h64);
    rdc(2'h1, REG_LINE_STATE, 8'h60);
    // host reset pin restores defaults
    @(posedge ref_clk);
    bus.reset <= 1'b1;
    cyc(6);
    bus.reset <= 1'b0;
    settle();
    rdc(2'h2, REG_SCRATCH, 8'h00);
    chk(8'({user_output_two_n, chan_one_irq_oe_n, chan_two_irq_oe_n}), 8'h0f);
    chk(8'(u_eng.n_drop), 8'h00);
    final_report();
  end
endmodule : testbench

/* File: uhp_eng_model.sv */
// Purpose: serial engine stand-in for both channels
// Assumes: same clock as the host port
// Notes: transmit side stalls on request; receive side sends on call
`timescale 1ns/1ps
module uhp_eng_model
  import uhp_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic [1:0] tx_valid, // offered bytes
  input wire logic [1:0][7:0] tx_data, // offered bytes
  output logic [1:0] tx_ready, // takes bytes
  output logic [1:0] rx_valid, // byte offered
  output logic [1:0][7:0] rx_data, // byte offered
  input wire logic [1:0] rx_ready, // room for byte
  input wire logic stall // hold off transmit
);
  logic [7:0] got [$]; // bytes taken from channel one
  int n_drop = 0; // offered bytes never taken
  // ==========================================================
  // take transmit bytes unless stalled
  always @(posedge ref_clk)
  begin
    tx_ready <= {2{~stall}};
    if (tx_valid[0] && tx_ready[0]) got.push_back(tx_data[0]);
  end
  initial
  begin
    rx_valid = 2'h0;
    rx_data = '0;
  end
  // offer one byte, hold it until taken, then show the inverse
  task automatic send(input logic ch, input logic [7:0] b);
    @(posedge ref_clk);
    rx_valid[ch] <= 1'b1;
    rx_data[ch] <= b;
    @(negedge ref_clk);
    for (int i = 0; i < 50 && !rx_ready[ch]; i++) @(negedge ref_clk);
    if (!rx_ready[ch]) n_drop++;
    @(posedge ref_clk);
    rx_valid[ch] <= 1'b0;
    rx_data[ch] <= ~b;
  endtask : send
endmodule : uhp_eng_model

/* File: uhp_host_port.sv */
// Purpose: host bus front end of a two-channel serial controller
// Assumes: bus pins asynchronous to ref_clk; serial engines outside
// Notes: bus pins pass three flops; writes commit at strobe release
`timescale 1ns/1ps
module uhp_host_port
  import uhp_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire uhp_bus_in_type bus_in, // raw bus pins incl. reset pin
  output logic [7:0] bus_data_out, // read data toward host
  output logic bus_data_oe_n, // low while driving data
  output logic chan_one_irq, // channel one interrupt level
  output logic chan_one_irq_oe_n, // low while irq one driven
  output logic chan_two_irq, // channel two interrupt level
  output logic chan_two_irq_oe_n, // low while irq two driven
  output logic [1:0] user_output_two_n, // auxiliary outputs
  output logic [1:0] receive_ready_n, // receive ready pins
  output logic [1:0] transmit_ready_n, // transmit ready pins
  output logic [1:0][7:0] line_format, // framing setup to engines
  output logic [1:0] tx_valid, // byte for transmit engine
  output logic [1:0][7:0] tx_data, // byte for transmit engine
  input wire logic [1:0] tx_ready, // transmit engine takes byte
  input wire logic [1:0] rx_valid, // byte from receive engine
  input wire logic [1:0][7:0] rx_data, // byte from receive engine
  output logic [1:0] rx_ready, // room for received byte
  input wire logic [1:0] rx_timeout, // receive time-out pulse
  input wire logic [1:0] rx_parity_err // parity error pulse
);
  uhp_top_state_type st;
  uhp_top_state_type next_st;
  logic [1:0] buf_in_ready;
  logic [1:0] buf_out_valid;

  // ==========================================================
  // helpers
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: return TRIG_L0;
      2'h1: return TRIG_L1;
      2'h2: return TRIG_L2;
      default: return TRIG_L3;
    endcase
  endfunction : trig_level

  function automatic logic [4:0] depth_of(input logic [7:0] ctl);
    return ctl[BUF_EN_BIT] ? FIFO_DEPTH : LEGACY_DEPTH;
  endfunction : depth_of

  function automatic uhp_fifo_type fifo_next(input uhp_fifo_type f, input logic clr,
                                             input logic push, input logic [7:0] d,
                                             input logic pop);
    uhp_fifo_type r;
    r = f;
    if (clr)
    begin
      r.rp = 4'h0;
      r.wp = 4'h0;
      r.cnt = 5'h00;
    end
    else
    begin
      if (push)
      begin
        r.mem[f.wp] = d;
        r.wp = f.wp + 4'h1;
      end
      if (pop)
        r.rp = f.rp + 4'h1;
      r.cnt = f.cnt + {4'h0, push} - {4'h0, pop};
    end
    return r;
  endfunction : fifo_next

  // receive and transmit interrupt sources
  function automatic logic [1:0] irq_src(input uhp_chan_cfg_type g, input uhp_fifo_type t,
                                         input uhp_fifo_type r);
    logic rx_s;
    logic tx_s;
    rx_s = g.buf_ctl[BUF_EN_BIT] ? (r.cnt >= trig_level(g.buf_ctl[TRIG_LO+:2]))
                                 : (r.cnt != 5'h00);
    tx_s = (t.cnt == 5'h00);
    return {tx_s & g.irq_en[IRQEN_TX_BIT], rx_s & g.irq_en[IRQEN_RX_BIT]};
  endfunction : irq_src

  // register read mux of one channel
  function automatic logic [7:0] read_byte(input uhp_chan_cfg_type g, input uhp_fifo_type t,
                                           input uhp_fifo_type r, input logic bufv,
                                           input logic [2:0] a);
    logic [7:0] v;
    logic [1:0] src;
    v = 8'h00;
    src = irq_src(g, t, r);
    case (a)
      REG_HOLD: v = r.mem[r.rp];
      REG_IRQ_EN: v = g.irq_en;
      REG_BUF_CTL:
      begin
        v[0] = ~(|src);
        v[3:1] = src[0] ? IRQ_ID_RX : (src[1] ? IRQ_ID_TX : 3'h0);
        v[7:6] = {2{g.buf_ctl[BUF_EN_BIT]}};
      end
      REG_LINE_FMT: v = g.line_fmt;
      REG_LINE_OUT: v = g.line_out;
      REG_LINE_STATE:
      begin
        v[LS_RX_AVAIL] = (r.cnt != 5'h00);
        v[LS_PARITY] = g.parity_err;
        v[LS_TX_EMPTY] = (t.cnt == 5'h00);
        v[LS_TX_IDLE] = (t.cnt == 5'h00) & ~bufv;
      end
      REG_MODEM_STAT: v = 8'h00;
      REG_SCRATCH: v = g.scratch;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  // reset image of the whole state
  function automatic uhp_top_state_type idle_state();
    uhp_top_state_type s;
    s = '0;
    s.s1 = BUS_IDLE;
    s.s2 = BUS_IDLE;
    s.s3 = BUS_IDLE;
    s.filt = BUS_IDLE;
    s.prev = BUS_IDLE;
    s.data_oe_n = 1'b1;
    s.rx_rdy_n = 2'h3;
    s.irq_oe_n = 2'h3;
    s.user2_n = 2'h3;
    s.rx_take = 2'h3;
    return s;
  endfunction : idle_state

  // ==========================================================
  // transmit path buffers toward the serial engines
  for (genvar c = 0; c < 2; c++)
  begin : g_txbuf
    uhp_skid2 u_skid (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(st.txf[c].cnt != 5'h00),
      .in_data(st.txf[c].mem[st.txf[c].rp]),
      .in_ready(buf_in_ready[c]),
      .out_valid(buf_out_valid[c]),
      .out_data(tx_data[c]),
      .out_ready(tx_ready[c])
    );
  end
  assign tx_valid = buf_out_valid;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic hrst;
    logic wr_end;
    logic rd_end;
    logic rd_act;
    logic [1:0] sel;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic fen;
    logic blk;
    logic tx_push;
    logic rx_pop;
    logic tx_clr;
    logic rx_clr;
    logic [7:0] ctl;
    logic [4:0] trig;
    logic [1:0] src;
    hrst = 1'b0;
    wr_end = 1'b0;
    rd_end = 1'b0;
    rd_act = 1'b0;
    sel = 2'h0;
    wsel = 2'h0;
    rsel = 2'h0;
    fen = 1'b0;
    blk = 1'b0;
    tx_push = 1'b0;
    rx_pop = 1'b0;
    tx_clr = 1'b0;
    rx_clr = 1'b0;
    ctl = 8'h00;
    trig = 5'h00;
    src = 2'h0;
    next_st = st;
    // three-flop pin sampling, a bit moves once stages two and three agree
    next_st.s1 = bus_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = uhp_bus_in_type'((st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3)));
    next_st.prev = st.filt;
    // host reset pin held for the least time
    next_st.rcnt = st.filt.reset ? ((st.rcnt == 4'hf) ? st.rcnt : st.rcnt + 4'h1) : 4'h0;
    hrst = st.filt.reset && (st.rcnt >= RESET_MIN_CYC - 4'h1);
    // bus decode from selects and strobes only
    sel = ~st.filt.select_n;
    wsel = ~st.prev.select_n;
    rsel = ~st.prev.select_n;
    wr_end = ~st.prev.write_n & st.filt.write_n;
    rd_end = ~st.prev.read_n & st.filt.read_n & st.prev.write_n;
    rd_act = ~st.filt.read_n & st.filt.write_n;
    // one shared data bus; a double select drives channel one data but a read pops or clears in both channels
    next_st.data_oe_n = ~(rd_act & (|sel));
    next_st.rd_data = sel[0] ? read_byte(st.cfg[0], st.txf[0], st.rxf[0], buf_out_valid[0],
                                         st.filt.addr)
                             : read_byte(st.cfg[1], st.txf[1], st.rxf[1], buf_out_valid[1],
                                         st.filt.addr);
    // per-channel registers and buffers, host accesses touch a channel only when selected
    for (int c = 0; c < 2; c++)
    begin
      ctl = st.cfg[c].buf_ctl;
      tx_push = 1'b0;
      tx_clr = 1'b0;
      rx_clr = 1'b0;
      rx_pop = rd_end & rsel[c] & (st.prev.addr == REG_HOLD) & (st.rxf[c].cnt != 5'h00);
      if (wr_end && wsel[c])
      begin
        case (st.prev.addr)
          REG_HOLD: tx_push = (st.txf[c].cnt < depth_of(ctl));
          REG_IRQ_EN: next_st.cfg[c].irq_en = st.prev.data;
          REG_BUF_CTL:
          begin
            next_st.cfg[c].buf_ctl = st.prev.data;
            next_st.cfg[c].buf_ctl[RX_CLR_BIT] = 1'b0;
            next_st.cfg[c].buf_ctl[TX_CLR_BIT] = 1'b0;
            rx_clr = st.prev.data[RX_CLR_BIT] | (st.prev.data[BUF_EN_BIT] ^ ctl[BUF_EN_BIT]);
            tx_clr = st.prev.data[TX_CLR_BIT] | (st.prev.data[BUF_EN_BIT] ^ ctl[BUF_EN_BIT]);
          end
          REG_LINE_FMT: next_st.cfg[c].line_fmt = st.prev.data;
          REG_LINE_OUT: next_st.cfg[c].line_out = st.prev.data;
          REG_SCRATCH: next_st.cfg[c].scratch = st.prev.data;
          default: ;
        endcase
      end
      // parity flag: a new error wins over the clearing read
      if (rd_end && rsel[c] && (st.prev.addr == REG_LINE_STATE))
        next_st.cfg[c].parity_err = 1'b0;
      if (rx_parity_err[c])
        next_st.cfg[c].parity_err = 1'b1;
      next_st.txf[c] = fifo_next(st.txf[c], tx_clr, tx_push, st.prev.data,
                                 (st.txf[c].cnt != 5'h00) & buf_in_ready[c]);
      next_st.rxf[c] = fifo_next(st.rxf[c], rx_clr, rx_valid[c] & st.rx_take[c],
                                 rx_data[c], rx_pop);
    end
    // reset pin restores bufferless defaults in both channels
    if (hrst)
    begin
      for (int c = 0; c < 2; c++)
      begin
        next_st.cfg[c] = '0;
        next_st.cfg[c].line_fmt = REG_RST;
        next_st.txf[c] = fifo_next(st.txf[c], 1'b1, 1'b0, 8'h00, 1'b0);
        next_st.rxf[c] = fifo_next(st.rxf[c], 1'b1, 1'b0, 8'h00, 1'b0);
      end
    end
    // pin levels from the updated state; ready pins are the only pacing
    for (int c = 0; c < 2; c++)
    begin
      ctl = next_st.cfg[c].buf_ctl;
      fen = ctl[BUF_EN_BIT];
      blk = fen & ctl[BLOCK_BIT];
      trig = trig_level(ctl[TRIG_LO+:2]);
      if (next_st.rxf[c].cnt == 5'h00)
        next_st.cfg[c].rx_block = 1'b0;
      else if ((next_st.rxf[c].cnt >= trig) || rx_timeout[c])
        next_st.cfg[c].rx_block = 1'b1;
      if (!blk)
        next_st.cfg[c].rx_block = 1'b0;
      next_st.rx_rdy_n[c] = blk ? ~next_st.cfg[c].rx_block
                                : (next_st.rxf[c].cnt == 5'h00);
      next_st.tx_rdy_n[c] = blk ? (next_st.txf[c].cnt == FIFO_DEPTH)
                                : (next_st.txf[c].cnt != 5'h00);
      src = irq_src(next_st.cfg[c], next_st.txf[c], next_st.rxf[c]);
      next_st.irq[c] = |src;
      next_st.irq_oe_n[c] = ~next_st.cfg[c].line_out[USER2_BIT];
      next_st.user2_n[c] = ~next_st.cfg[c].line_out[USER2_BIT];
      next_st.rx_take[c] = (next_st.rxf[c].cnt < depth_of(ctl));
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= idle_state();
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs, all from state flops
  assign bus_data_out = st.rd_data;
  assign bus_data_oe_n = st.data_oe_n;
  assign chan_one_irq = st.irq[0];
  assign chan_one_irq_oe_n = st.irq_oe_n[0];
  assign chan_two_irq = st.irq[1];
  assign chan_two_irq_oe_n = st.irq_oe_n[1];
  assign user_output_two_n = st.user2_n;
  assign receive_ready_n = st.rx_rdy_n;
  assign transmit_ready_n = st.tx_rdy_n;
  assign line_format = {st.cfg[1].line_fmt, st.cfg[0].line_fmt};
  assign rx_ready = st.rx_take;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_no_select_quiet:
  assert property (st.filt.select_n == 2'h3 |=> bus_data_oe_n)
    else $error("data bus driven with no channel selected");
  a_drive_needs_read:
  assert property (!bus_data_oe_n |-> $past(!st.filt.read_n && st.filt.write_n))
    else $error("data bus driven outside a read strobe");
  a_reset_pin_defaults:
  assert property (st.filt.reset |=> st.cfg[0].buf_ctl == 8'h00 && st.cfg[1].buf_ctl == 8'h00
                   ##1 chan_one_irq_oe_n && chan_two_irq_oe_n)
    else $error("reset pin did not restore channel defaults");
  a_write_one_only:
  assert property (!st.prev.write_n && st.filt.write_n && st.prev.select_n == 2'h2
                   |=> $stable(st.cfg[1].buf_ctl) && $stable(st.cfg[1].line_out))
    else $error("write to channel one altered channel two");
  a_fifo_bound:
  assert property (st.txf[0].cnt <= FIFO_DEPTH && st.rxf[0].cnt <= FIFO_DEPTH)
    else $error("buffer count above sixteen");
  a_block_tx_full:
  assert property (st.cfg[0].buf_ctl[BUF_EN_BIT] && st.cfg[0].buf_ctl[BLOCK_BIT]
                   |-> transmit_ready_n[0] == (st.txf[0].cnt == FIFO_DEPTH))
    else $error("block transmit ready wrong");
  a_plain_rx_ready:
  assert property (!st.cfg[1].buf_ctl[BLOCK_BIT]
                   |-> receive_ready_n[1] == (st.rxf[1].cnt == 5'h00))
    else $error("receive ready wrong outside block mode");
  a_block_rx_rise:
  assert property (st.cfg[1].buf_ctl[BUF_EN_BIT] && st.cfg[1].buf_ctl[BLOCK_BIT]
                   && st.rxf[1].cnt == 5'h00 |-> receive_ready_n[1])
    else $error("block receive ready low with empty buffer");
  a_tx_irq_empty:
  assert property (st.cfg[0].irq_en == 8'h02 && $changed(st.txf[0].cnt)
                   |-> chan_one_irq == (st.txf[0].cnt == 5'h00))
    else $error("transmit interrupt does not follow empty buffer");
  a_user2_pair:
  assert property ($rose(st.cfg[1].line_out[USER2_BIT])
                   |-> !chan_two_irq_oe_n && !user_output_two_n[1] ##1 !chan_two_irq_oe_n)
    else $error("output-two bit did not drive interrupt pin");
endmodule : uhp_host_port

/* File: uhp_pkg.sv */
// Purpose: shared constants and types of the two-channel host port
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: register index within a channel is the three address lines
// How it works
// - byte-wide data, three address lines per access
// - bus cycles need only selects and strobes
// - both channels share one host data bus
// - high reset pin restores both channel defaults
// - select pins pick none, one, other, both
// - each channel owns separate register set
// - sixteen-byte transmit and receive buffers each
// - four receive thresholds raise receive request
// - framing and parity options, parity errors flagged
// - after reset behaves as bufferless legacy model
// - no memory-access handshake, only ready pins
// - block bit selects block transfer pacing
// - outside block, receive ready low when data
// - block receive ready falls trigger, rises empty
// - outside block, transmit ready low when empty
// - block transmit ready high only when full
// - transmit interrupt high when transmit buffer empty
// - receive interrupt high at receive threshold
// - output-two bit drives interrupt, lowers auxiliary
package uhp_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS = 40;
  localparam logic [3:0] RESET_MIN_CYC = 4'((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ==========================================================
  // register indices within a channel
  localparam logic [2:0] REG_HOLD = 3'h0;
  localparam logic [2:0] REG_IRQ_EN = 3'h1;
  localparam logic [2:0] REG_BUF_CTL = 3'h2;
  localparam logic [2:0] REG_LINE_FMT = 3'h3;
  localparam logic [2:0] REG_LINE_OUT = 3'h4;
  localparam logic [2:0] REG_LINE_STATE = 3'h5;
  localparam logic [2:0] REG_MODEM_STAT = 3'h6;
  localparam logic [2:0] REG_SCRATCH = 3'h7;
  // ==========================================================
  // field positions
  localparam int BUF_EN_BIT = 0;
  localparam int RX_CLR_BIT = 1;
  localparam int TX_CLR_BIT = 2;
  localparam int BLOCK_BIT = 3;
  localparam int TRIG_LO = 6;
  localparam int USER2_BIT = 3;
  localparam int IRQEN_RX_BIT = 0;
  localparam int IRQEN_TX_BIT = 1;
  localparam int LS_RX_AVAIL = 0;
  localparam int LS_PARITY = 2;
  localparam int LS_TX_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  // ==========================================================
  // depths, thresholds, reset values
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] LEGACY_DEPTH = 5'h01;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] IRQ_ID_RX = 3'h2;
  localparam logic [2:0] IRQ_ID_TX = 3'h1;
  // ==========================================================
  // types
  typedef struct packed {
    logic reset;
    logic [1:0] select_n;
    logic read_n;
    logic write_n;
    logic [2:0] addr;
    logic [7:0] data;
  } uhp_bus_in_type;
  localparam uhp_bus_in_type BUS_IDLE = '{1'b0, 2'h3, 1'b1, 1'b1, 3'h0, 8'h00};
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0] rp;
    logic [3:0] wp;
    logic [4:0] cnt;
  } uhp_fifo_type;
  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] buf_ctl;
    logic [7:0] line_fmt;
    logic [7:0] line_out;
    logic [7:0] scratch;
    logic parity_err;
    logic rx_block;
  } uhp_chan_cfg_type;
  typedef struct packed {
    logic [7:0] e0;
    logic [7:0] e1;
    logic v0;
    logic v1;
  } uhp_skid_state_type;
  typedef struct packed {
    uhp_bus_in_type s1;
    uhp_bus_in_type s2;
    uhp_bus_in_type s3;
    uhp_bus_in_type filt;
    uhp_bus_in_type prev;
    logic [3:0] rcnt;
    uhp_chan_cfg_type [1:0] cfg;
    uhp_fifo_type [1:0] txf;
    uhp_fifo_type [1:0] rxf;
    logic [7:0] rd_data;
    logic data_oe_n;
    logic [1:0] rx_rdy_n;
    logic [1:0] tx_rdy_n;
    logic [1:0] irq;
    logic [1:0] irq_oe_n;
    logic [1:0] user2_n;
    logic [1:0] rx_take;
  } uhp_top_state_type;
endpackage : uhp_pkg

/* File: uhp_skid2.sv */
// Purpose: two-entry buffer between transmit buffer and serial engine
// Assumes: same clock as the host port
// Notes: head entry always sits in e0, so outputs are plain flops
`timescale 1ns/1ps
module uhp_skid2
  import uhp_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic in_valid, // word offered
  input wire logic [7:0] in_data, // word offered
  output logic in_ready, // room for a word
  output logic out_valid, // head word present
  output logic [7:0] out_data, // head word
  input wire logic out_ready // receiver takes head
);
  uhp_skid_state_type st;
  uhp_skid_state_type next_st;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid & ~st.v1;
  assign pop = st.v0 & out_ready;

  // shift-style update of two entries
  always_comb
  begin
    next_st = st;
    if (pop)
    begin
      next_st.e0 = st.v1 ? st.e1 : in_data;
      next_st.v0 = st.v1 | push;
      next_st.v1 = st.v1 & push;
      if (st.v1 & push)
        next_st.e1 = in_data;
    end
    else if (push)
    begin
      if (!st.v0)
      begin
        next_st.e0 = in_data;
        next_st.v0 = 1'b1;
      end
      else
      begin
        next_st.e1 = in_data;
        next_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign in_ready = ~st.v1;
  assign out_valid = st.v0;
  assign out_data = st.e0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_skid_hold_head:
  assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled head word changed or vanished");
endmodule : uhp_skid2
